// ===== core/mfv_consts.vh
// Constants for the flow control, tag compare and wake filter block
`ifndef MFV_CONSTS_VH
`define MFV_CONSTS_VH

// ***************************************
// Register indices (byte address = 4 x index)
// ***************************************
`define MFV_IDX_FLOW 4'h8
`define MFV_IDX_TAG1 4'h9
`define MFV_IDX_TAG2 4'ha
`define MFV_IDX_WAKE 4'hb
`define MFV_IDX_CTRL 4'hc
`define MFV_ADDR_W 8

// ***************************************
// Flow control register fields
// ***************************************
`define MFV_FLOW_BUSY 0
`define MFV_FLOW_EN 1
`define MFV_FLOW_PASS 2
`define MFV_FLOW_QT_LO 16
`define MFV_FLOW_QT_HI 31

// ***************************************
// Extra control register fields
// ***************************************
`define MFV_CTRL_FDX 0
`define MFV_CTRL_TXEN 1
`define MFV_CTRL_SPD100 2
`define MFV_CTRL_SOFTRST 3
`define MFV_CTRL_BP 4

// ***************************************
// Reset values
// ***************************************
`define MFV_RST_WORD 32'h00000000
`define MFV_RST_CTRL 5'h00

// ***************************************
// Frame length limits
// ***************************************
`define MFV_MAX_LEN 11'h5ee
`define MFV_MAX_LEN_VLAN 11'h5f2

// ***************************************
// Timing: one pause quantum is 512 bit times
// ***************************************
`define MFV_QUANTUM_BITS 512
`define MFV_BIT_NS_100 10
`define MFV_BIT_NS_10 100
`define MFV_CLK_NS 10
`define MFV_CYC_Q100 ((`MFV_QUANTUM_BITS * `MFV_BIT_NS_100 + `MFV_CLK_NS - 1) / `MFV_CLK_NS)
`define MFV_CYC_Q10 ((`MFV_QUANTUM_BITS * `MFV_BIT_NS_10 + `MFV_CLK_NS - 1) / `MFV_CLK_NS)

// Opcode of a pause control frame
`define MFV_PAUSE_OP 16'h0001
`define MFV_CTRL_TYPE 16'h8808

`endif

// ===== core/mfv_filter_mem.v
// Eight-word wake-up filter store with registered read data
`timescale 1ns/1ns
`default_nettype none
module mfv_filter_mem #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock
  input wire clk,
  // Write side
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  // Read side for the wake matcher
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);

  // Storage array
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // ***************************************
  // Write and registered read
  // ***************************************
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule
`default_nettype wire

// ===== core/mfv_top.v
// Pause flow control, backpressure, VLAN tag compare and wake filter loader
//
// Added by the designer: the address-and-strobe port.
`include "mfv_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module mfv_top #(
  parameter FILT_W = 32,
  parameter FILT_DEPTH = 8,
  parameter FILT_AW = 3,
  parameter QCYC_100 = `MFV_CYC_Q100,
  parameter QCYC_10 = `MFV_CYC_Q10
) (
  // Clock and reset
  input wire CLK_SYS,
  input wire RESET_N,
  // Register port
  input wire [`MFV_ADDR_W-1:0] REG_ADDR,
  input wire [31:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [31:0] REG_RDATA,
  // Receive byte stream from the MAC core
  input wire RX_SOF,
  input wire RX_VALID,
  input wire [7:0] RX_DATA,
  input wire RX_EOF,
  // Transmit side handshake
  input wire PAUSE_TX_DONE,
  input wire TX_FRAME_END,
  // Receive congestion indication from the buffers
  input wire RX_CONGESTED,
  // Results
  output reg TX_HOLD,
  output reg PAUSE_TX_REQ,
  output reg [15:0] PAUSE_TX_TIME,
  output reg BACKPRESSURE,
  output reg VLAN_ONE,
  output reg VLAN_TWO,
  output reg [10:0] MAX_FRAME_LEN,
  output reg RX_TOO_LONG,
  output reg [31:0] WAKE_WORD
);

  // ***************************************
  // Registers
  // ***************************************
  reg [15:0] quantum;    // Pause time to send
  reg flow_en;           // Flow control enable
  reg flow_pass;         // Pass control frames, stored only
  reg [15:0] tag_one;    // First tag identifier
  reg [15:0] tag_two;    // Second tag identifier
  reg [4:0] ctrl;        // Duplex, tx enable, speed, soft reset, bp request
  reg [FILT_AW-1:0] wptr; // Filter load pointer
  reg busy;              // Pause send or backpressure in progress

  // Local decode of the word index
  // Only word indices 8 to 12 are decoded, the rest read zero
  wire [5:0] idx = REG_ADDR[7:2];
  wire fdx = ctrl[`MFV_CTRL_FDX];
  wire tx_en = ctrl[`MFV_CTRL_TXEN];
  // Soft reset is decoded straight from the write, it is never stored
  wire soft_rst = REG_WR && idx == {2'b00, `MFV_IDX_CTRL} && REG_WDATA[`MFV_CTRL_SOFTRST];

  // ***************************************
  // Register writes
  // ***************************************
  // Software writes; unmapped indices are dropped silently
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      quantum <= 16'h0000;
      flow_en <= 1'b0;
      flow_pass <= 1'b0;
      tag_one <= 16'h0000;
      tag_two <= 16'h0000;
      ctrl <= `MFV_RST_CTRL;
    end else if (REG_WR) begin
      // Decode the word index of the write
      case (idx)
        {2'b00, `MFV_IDX_FLOW}: begin
          // Busy bit position is ignored on write
          quantum <= REG_WDATA[`MFV_FLOW_QT_HI:`MFV_FLOW_QT_LO];
          flow_en <= REG_WDATA[`MFV_FLOW_EN];
          flow_pass <= REG_WDATA[`MFV_FLOW_PASS];
        end
        {2'b00, `MFV_IDX_TAG1}: tag_one <= REG_WDATA[15:0];
        {2'b00, `MFV_IDX_TAG2}: tag_two <= REG_WDATA[15:0];
        // Soft reset bit is a pulse, never stored
        {2'b00, `MFV_IDX_CTRL}: ctrl <= {REG_WDATA[4], 1'b0, REG_WDATA[2:0]};
        default: ctrl <= ctrl;
      endcase
    end
  end

  // ***************************************
  // Wake filter pointer and store
  // ***************************************
  // A write to the filter port stores at the pointer, then steps it
  // Reads never touch the pointer, the port is write-only
  wire wake_wr = REG_WR && idx == {2'b00, `MFV_IDX_WAKE};

  // Pointer restarts on hard and soft reset
  always @(posedge CLK_SYS) begin
    if (!RESET_N || soft_rst) begin
      wptr <= {FILT_AW{1'b0}};
    end else if (wake_wr) begin
      // Natural wrap at eight words
      wptr <= wptr + 1'b1;
    end
  end

  // Readback pointer for the wake matcher, walks the words
  // It runs free so every word comes round once in eight cycles
  reg [FILT_AW-1:0] rptr;
  wire [FILT_W-1:0] filt_q;
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      rptr <= {FILT_AW{1'b0}};
    end else begin
      rptr <= rptr + 1'b1;
    end
  end

  // Write side is the filter port, read side feeds the matcher
  mfv_filter_mem #(
    .WIDTH(FILT_W),
    .DEPTH(FILT_DEPTH),
    .AW(FILT_AW)
  ) u_mem (
    .clk(CLK_SYS),
    .wr_en(wake_wr),
    .wr_addr(wptr),
    .wr_data(REG_WDATA[FILT_W-1:0]),
    .rd_addr(rptr),
    .rd_data(filt_q)
  );

  // ***************************************
  // Register reads, data one cycle later
  // ***************************************
  // Busy reads back live, never the written value
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      REG_RDATA <= `MFV_RST_WORD;
    end else if (REG_RD) begin
      case (idx)
        {2'b00, `MFV_IDX_FLOW}: REG_RDATA <= {quantum, 13'h0000, flow_pass, flow_en, busy};
        {2'b00, `MFV_IDX_TAG1}: REG_RDATA <= {16'h0000, tag_one};
        {2'b00, `MFV_IDX_TAG2}: REG_RDATA <= {16'h0000, tag_two};
        // Write-only port reads as zero
        {2'b00, `MFV_IDX_WAKE}: REG_RDATA <= 32'h00000000;
        {2'b00, `MFV_IDX_CTRL}: REG_RDATA <= {27'h0000000, ctrl};
        default: REG_RDATA <= 32'h00000000;
      endcase
    end else begin
      // Data stand for one cycle only, then zero
      REG_RDATA <= 32'h00000000;
    end
  end

  // ***************************************
  // Receive byte counter and header capture
  // ***************************************
  reg [10:0] bcnt;       // Bytes seen so far in frame
  reg [15:0] etype;      // Bytes 13 and 14
  reg [15:0] opcode;     // Bytes 15 and 16
  reg [15:0] rx_qt;      // Bytes 17 and 18
  reg in_frame;
  wire [10:0] pos = RX_SOF ? 11'h000 : bcnt;

  // Header fields are caught by byte position
  // Everything after byte 18 is only counted
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      bcnt <= 11'h000;
      etype <= 16'h0000;
      opcode <= 16'h0000;
      rx_qt <= 16'h0000;
      in_frame <= 1'b0;
    end else if (RX_VALID) begin
      in_frame <= !RX_EOF;
      // Counter saturates so a runaway frame cannot wrap to zero
      if (bcnt != 11'h7ff || RX_SOF) begin
        bcnt <= pos + 11'h001;
      end
      case (pos)
        11'd12: etype[15:8] <= RX_DATA;
        11'd13: etype[7:0] <= RX_DATA;
        11'd14: opcode[15:8] <= RX_DATA;
        11'd15: opcode[7:0] <= RX_DATA;
        11'd16: rx_qt[15:8] <= RX_DATA;
        11'd17: rx_qt[7:0] <= RX_DATA;
        default: etype <= etype;
      endcase
    end
  end

  // ***************************************
  // VLAN detect and length check
  // ***************************************
  // Both compares run side by side
  wire hit_one = etype == tag_one;
  wire hit_two = etype == tag_two;
  // Compares wait until both type bytes are in
  wire hdr_ok = bcnt >= 11'd14;
  wire vlan_any = hdr_ok && (hit_one || hit_two);
  wire [10:0] next_limit = vlan_any ? `MFV_MAX_LEN_VLAN : `MFV_MAX_LEN;

  // Limits and flags are registered so every output leaves a flip-flop
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      VLAN_ONE <= 1'b0;
      VLAN_TWO <= 1'b0;
      MAX_FRAME_LEN <= `MFV_MAX_LEN;
      RX_TOO_LONG <= 1'b0;
    end else begin
      VLAN_ONE <= hdr_ok && hit_one;
      VLAN_TWO <= hdr_ok && hit_two;
      // Tagged frames get four more bytes
      MAX_FRAME_LEN <= next_limit;
      // Sticky until the next frame starts
      if (RX_SOF && RX_VALID) begin
        RX_TOO_LONG <= 1'b0;
      end else if (RX_VALID && in_frame && pos >= next_limit) begin
        // Byte index at the limit means one byte too many
        RX_TOO_LONG <= 1'b1;
      end
    end
  end

  // ***************************************
  // Pause decode and hold-off timer
  // ***************************************
  // Decode only with enable and full duplex
  // Frame must reach the quantum bytes before its end counts
  wire pause_seen = RX_VALID && RX_EOF && flow_en && fdx && bcnt >= 11'd17 &&
                    etype == `MFV_CTRL_TYPE && opcode == `MFV_PAUSE_OP;
  // Cycles per quantum depend on the link speed bit
  wire [15:0] qcyc = ctrl[`MFV_CTRL_SPD100] ? QCYC_100[15:0] : QCYC_10[15:0];
  // Pause timer, two counters so the slow speed fits 16 bits
  reg [15:0] qleft;      // Quanta still to wait
  reg [15:0] cyc;        // Cycles left in current quantum

  // Restart on each new pause frame
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      qleft <= 16'h0000;
      cyc <= 16'h0000;
      TX_HOLD <= 1'b0;
    end else if (!flow_en || !fdx) begin
      // Disabling flow control or leaving full duplex drops any hold
      qleft <= 16'h0000;
      cyc <= 16'h0000;
      TX_HOLD <= 1'b0;
    end else if (pause_seen) begin
      // Quantum times slot time
      qleft <= rx_qt;
      cyc <= qcyc;
      TX_HOLD <= rx_qt != 16'h0000;
    end else if (qleft != 16'h0000) begin
      if (cyc <= 16'h0001) begin
        // Quantum over: reload and count one down
        cyc <= qcyc;
        qleft <= qleft - 16'h0001;
        TX_HOLD <= qleft != 16'h0001;
      end else begin
        // Still inside the quantum
        cyc <= cyc - 16'h0001;
      end
    end else begin
      // No quanta left
      TX_HOLD <= 1'b0;
    end
  end

  // ***************************************
  // Pause send, backpressure and busy flag
  // ***************************************
  // Software asks for a pause send by a flow write with enable in full duplex
  wire flow_wr = REG_WR && idx == {2'b00, `MFV_IDX_FLOW};
  // A zero quantum is still sent, it releases a paused partner
  wire send_req = flow_wr && REG_WDATA[`MFV_FLOW_EN] && fdx;
  // Backpressure follows the congestion level or the force bit
  wire bp_want = flow_en && !fdx && tx_en && (RX_CONGESTED || ctrl[`MFV_CTRL_BP]);

  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      PAUSE_TX_REQ <= 1'b0;
      PAUSE_TX_TIME <= 16'h0000;
      BACKPRESSURE <= 1'b0;
      busy <= 1'b0;
    end else begin
      // Backpressure only in half duplex and tx on
      BACKPRESSURE <= bp_want;
      if (!tx_en) begin
        // Transmitter off cancels any send
        PAUSE_TX_REQ <= 1'b0;
      end else if (send_req && !PAUSE_TX_REQ) begin
        PAUSE_TX_REQ <= 1'b1;
        // Upper half gives the time field
        PAUSE_TX_TIME <= REG_WDATA[`MFV_FLOW_QT_HI:`MFV_FLOW_QT_LO];
      end else if (PAUSE_TX_DONE) begin
        // Cleared once the frame is out
        PAUSE_TX_REQ <= 1'b0;
      end
      // High for whole send or backpressure
      // A new send request counts as busy in the very cycle it is taken
      busy <= (PAUSE_TX_REQ && !PAUSE_TX_DONE && tx_en) ||
              (send_req && tx_en && !PAUSE_TX_REQ) || bp_want;
    end
  end

  // ***************************************
  // Filter word presented to the wake matcher
  // ***************************************
  // Two cycles behind the read pointer: memory register, then this one
  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      WAKE_WORD <= `MFV_RST_WORD;
    end else begin
      WAKE_WORD <= filt_q;
    end
  end

endmodule
`default_nettype wire

// ===== sim/mfv_link_model.sv
// Link partner model: receive frames and pause send acknowledge
`timescale 1ns/1ns
`default_nettype none
module mfv_link_model #(
  parameter int DONE_DLY = 10
) (
  // Clock
  input wire logic clk,
  // Receive byte stream into the block
  output logic rx_sof,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_eof,
  // Pause send handshake
  input wire logic pause_tx_req,
  output logic pause_tx_done
);
  logic sending; // High while a frame is on the wire
  int dcnt; // Cycles the pause request has waited
  initial begin
    {rx_sof, rx_valid, rx_eof, pause_tx_done, sending} = 5'h00;
    rx_data = 8'h00;
    dcnt = 0;
  end
  // Idle data toggles so a stale byte never looks valid
  always @(posedge clk) begin
    if (!sending) begin
      rx_data <= ~rx_data;
    end
  end
  // Pause frame leaves the wire a while after the request
  always @(posedge clk) begin
    pause_tx_done <= 1'b0;
    if (pause_tx_req && !pause_tx_done) begin
      dcnt <= dcnt + 1;
      if (dcnt == DONE_DLY) begin
        pause_tx_done <= 1'b1;
        dcnt <= 0;
      end
    end
  end
  // Frame of n bytes, type t at bytes 12-13, opcode and quanta after
  task automatic send(input logic [15:0] t, input logic [15:0] q, input int n);
    logic [7:0] b;
    @(posedge clk) sending <= 1'b1;
    for (int i = 0; i < n; i++) begin
      b = (i == 12) ? t[15:8] : (i == 13) ? t[7:0] : (i == 14) ? 8'h00 : (i == 15) ? 8'h01 :
          (i == 16) ? q[15:8] : (i == 17) ? q[7:0] : 8'($urandom);
      @(posedge clk) begin
        rx_valid <= 1'b1;
        rx_sof <= (i == 0);
        rx_eof <= (i == n - 1);
        rx_data <= b;
      end
    end
    @(posedge clk) {rx_valid, rx_eof, sending} <= 3'h0;
    // One more edge so results of the last byte have settled
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== sim/mfv_monitor.sv
// Checker of flow control, tag compare and filter port behaviour
`timescale 1ns/1ns
`default_nettype none
module mfv_monitor (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [31:0] REG_WDATA,
  input wire logic [31:0] REG_RDATA,
  // Frame and pause signals
  input wire logic RX_VALID,
  input wire logic RX_EOF,
  input wire logic PAUSE_TX_DONE,
  input wire logic PAUSE_TX_REQ,
  input wire logic [15:0] PAUSE_TX_TIME,
  input wire logic TX_HOLD,
  input wire logic BACKPRESSURE,
  input wire logic VLAN_ONE,
  input wire logic [10:0] MAX_FRAME_LEN
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  // ****************
  // Register port
  // ****************
  chk_rd_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data outside its slot");
  chk_wake_wo: assert property (REG_RD && REG_ADDR == 8'h2c |=> REG_RDATA == 32'h0)
    else $error("filter port gave data");
  // ****************
  // Pause and backpressure
  // ****************
  chk_req_time: assert property ($rose(PAUSE_TX_REQ) |-> $past(REG_WR) && PAUSE_TX_TIME == $past(REG_WDATA[31:16]))
    else $error("pause time not from flow word");
  chk_req_stand: assert property (PAUSE_TX_REQ && !PAUSE_TX_DONE |=> PAUSE_TX_REQ && $stable(PAUSE_TX_TIME))
    else $error("pause request dropped early");
  chk_done_drop: assert property (PAUSE_TX_DONE && PAUSE_TX_REQ |=> !PAUSE_TX_REQ)
    else $error("pause request outlived done");
  chk_hold_cause: assert property ($rose(TX_HOLD) |-> $past(RX_VALID && RX_EOF))
    else $error("hold without frame end");
  chk_dup_excl: assert property (!(BACKPRESSURE && PAUSE_TX_REQ))
    else $error("pause and backpressure together");
  // ****************
  // Frame length
  // ****************
  chk_len_vals: assert property (MAX_FRAME_LEN == 11'h5ee || MAX_FRAME_LEN == 11'h5f2)
    else $error("odd length limit");
  chk_vlan_len: assert property ($rose(VLAN_ONE) |-> ##[0:2] MAX_FRAME_LEN == 11'h5f2)
    else $error("tagged frame kept short limit");
  // Main scenarios reached
  cover property ($fell(TX_HOLD));
  cover property ($rose(BACKPRESSURE));
  cover property (PAUSE_TX_DONE && PAUSE_TX_REQ);
endmodule
bind mfv_top mfv_monitor mfv_monitor_i (.*);
`default_nettype wire

// ===== sim/mfv_top_test.sv
// Self-checking bench of the flow control and tag compare block
`timescale 1ns/1ns
`default_nettype none
module mfv_top_test;
  logic CLK_SYS = 0, RESET_N = 0, REG_WR = 0, REG_RD = 0, RX_CONGESTED = 0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0;
  wire RX_SOF, RX_VALID, RX_EOF, PAUSE_TX_DONE, TX_HOLD, PAUSE_TX_REQ;
  wire BACKPRESSURE, VLAN_ONE, VLAN_TWO, RX_TOO_LONG;
  wire [7:0] RX_DATA;
  wire [15:0] PAUSE_TX_TIME;
  wire [10:0] MAX_FRAME_LEN;
  wire [31:0] REG_RDATA, WAKE_WORD;
  wire TX_FRAME_END = 1'b0; // Unused by the block
  int bad_count = 0, check_count = 0, hold_n = 0, k;
  logic rd_d = 0; // Read issued one cycle ago
  logic [31:0] rq[$], wv[8], seen[16];
  logic [15:0] t2, q;
  always #5 CLK_SYS = ~CLK_SYS;
  mfv_top #(.QCYC_100(4), .QCYC_10(8)) mfv_top_i (.*);
  mfv_link_model mfv_link_model_i (.clk(CLK_SYS), .rx_sof(RX_SOF), .rx_valid(RX_VALID), .rx_data(RX_DATA),
    .rx_eof(RX_EOF), .pause_tx_req(PAUSE_TX_REQ), .pause_tx_done(PAUSE_TX_DONE));
  // ****************
  // Compare, bus tasks and result watcher
  // ****************
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS) {REG_ADDR, REG_WDATA, REG_WR} <= {a, d, 1'b1};
    @(posedge CLK_SYS) REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLK_SYS) {REG_ADDR, REG_RD} <= {a, 1'b1};
    rq.push_back(e);
    @(posedge CLK_SYS) REG_RD <= 1'b0;
  endtask
  // Read data is taken in its single slot and matched to the oldest note
  always @(posedge CLK_SYS) begin
    if (rd_d) chk(rq.pop_front(), REG_RDATA);
    rd_d <= REG_RD;
    if (TX_HOLD) hold_n++;
  end
  // Frame then the hold cycles it caused
  task automatic pause_rx(input logic [31:0] e);
    hold_n = 0;
    mfv_link_model_i.send(16'h8808, q, 64);
    repeat (q * 8 + 6) @(posedge CLK_SYS);
    chk(e, hold_n);
  endtask
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard, far beyond the few thousand cycles the tests need
  initial begin
    #500000;
    bad_count++;
    print_verdict;
  end
  initial begin
    void'($urandom(32'he326));
    repeat (10) @(posedge CLK_SYS);
    RESET_N <= 1'b1;
    for (int i = 8; i < 16; i++) rd(8'(i * 4), 32'h0); // Reset values, unmapped 0x34-0x3c
    // Filter words, wrap, soft reset restarts at word zero
    foreach (wv[i]) begin wv[i] = $urandom; wr(8'h2c, wv[i]); end
    wr(8'h2c, $urandom);
    wr(8'h30, 32'h8);
    wr(8'h2c, wv[0]);
    rd(8'h2c, 32'h0);
    for (int i = 0; i < 16; i++) @(posedge CLK_SYS) seen[i] = WAKE_WORD;
    k = 0;
    for (int i = 0; i < 8; i++) if (seen[i] === wv[0]) k = i;
    for (int j = 0; j < 8; j++) chk(wv[j], seen[k + j]);
    // Tag identifiers and length limit
    t2 = 16'h4000 | 15'($urandom);
    wr(8'h24, 32'h8100);
    wr(8'h28, {16'h0, t2});
    rd(8'h24, 32'h8100);
    rd(8'h28, {16'h0, t2});
    mfv_link_model_i.send(16'h0800, 0, 1519);
    chk(1, RX_TOO_LONG);
    mfv_link_model_i.send(16'h8100, 0, 1522);
    chk({1'b1, 11'h5f2}, {VLAN_ONE, MAX_FRAME_LEN});
    chk(0, RX_TOO_LONG);
    mfv_link_model_i.send(t2, 0, 64);
    chk(1, VLAN_TWO);
    // Pause decode at both speeds, then disabled
    q = 16'(1 + $urandom % 4);
    wr(8'h30, 32'h3);
    wr(8'h20, 32'h2);
    pause_rx(q * 8);
    wr(8'h30, 32'h7);
    pause_rx(q * 4);
    wr(8'h20, 32'h0);
    pause_rx(0);
    // Half duplex: backpressure in place of pause
    wr(8'h30, 32'h2);
    wr(8'h20, 32'h2);
    pause_rx(0);
    RX_CONGESTED <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    chk(1, BACKPRESSURE);
    rd(8'h20, 32'h3);
    wr(8'h30, 32'h0);
    repeat (3) @(posedge CLK_SYS);
    chk(0, BACKPRESSURE);
    RX_CONGESTED <= 1'b0;
    // Force bit alone, half duplex with transmitter on
    wr(8'h30, 32'h12);
    repeat (3) @(posedge CLK_SYS);
    chk(1, BACKPRESSURE);
    // Pause send with busy, then with transmitter off
    wr(8'h30, 32'h3);
    wr(8'h20, {q, 16'h2});
    rd(8'h20, {q, 16'h3});
    chk(q, PAUSE_TX_TIME);
    for (int i = 0; i < 50 && PAUSE_TX_REQ !== 1'b0; i++) @(posedge CLK_SYS);
    rd(8'h20, {q, 16'h2});
    wr(8'h30, 32'h1);
    wr(8'h20, {q, 16'h2});
    repeat (3) @(posedge CLK_SYS);
    chk(0, PAUSE_TX_REQ);
    repeat (3) @(posedge CLK_SYS);
    print_verdict;
  end
endmodule
`default_nettype wire
